//--- cpu_bus_pkg.sv
// constants, vectors and sequencer states shared by the bus control block
`default_nettype none

package cpu_bus_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 5;
    localparam int SYNC_N = 3;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_NS      = 40;
    localparam int CYCLE_NS    = 1000;
    localparam int RDY_LATE_NS = 100;
    // shortest cycle rounds up, late ready window rounds down
    localparam int CYCLE_CLKS    = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int PHI1_CLKS     = CYCLE_CLKS / 2;
    localparam int RDY_LATE_RAW  = RDY_LATE_NS / CLK_NS;
    localparam int RDY_LATE_CLKS = (RDY_LATE_RAW < 1) ? 1 : RDY_LATE_RAW;

    localparam logic [CNT_W-1:0] CNT_STEP   = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_LAST   = CNT_W'(CYCLE_CLKS - 1);
    localparam logic [CNT_W-1:0] PHI1_LAST  = CNT_W'(PHI1_CLKS - 2);
    localparam logic [CNT_W-1:0] PHI2_START = CNT_W'(PHI1_CLKS);
    localparam logic [CNT_W-1:0] PHI2_LAST  = CNT_W'(CYCLE_CLKS - 2);
    localparam logic [CNT_W-1:0] RDY_SAMPLE = CNT_W'(PHI1_CLKS + RDY_LATE_CLKS);

    // ****************************************
    // pin synchroniser lanes
    // ****************************************
    localparam int IN_READY = 0;
    localparam int IN_IRQ   = 1;
    localparam int IN_GATE  = 2;
    localparam logic [SYNC_N-1:0] SYNC_RESET = 3'h3;

    // ****************************************
    // vectors and stack
    // ****************************************
    localparam logic [ADDR_W-1:0] VEC_IRQ_LO = 16'hFFFE;
    localparam logic [ADDR_W-1:0] VEC_IRQ_HI = 16'hFFFF;
    localparam logic [ADDR_W-1:0] VEC_RST_LO = 16'hFFFC;
    localparam logic [ADDR_W-1:0] VEC_RST_HI = 16'hFFFD;
    localparam logic [DATA_W-1:0] STACK_PAGE = 8'h01;
    localparam logic [DATA_W-1:0] SP_DEC     = 8'h01;
    localparam logic              MASK_RESET = 1'h1;

    typedef enum logic [2:0] {
        ST_RST_LO   = 3'h0,
        ST_RST_HI   = 3'h1,
        ST_RUN      = 3'h2,
        ST_PUSH_PCH = 3'h3,
        ST_PUSH_PCL = 3'h4,
        ST_PUSH_P   = 3'h5,
        ST_VEC_LO   = 3'h6,
        ST_VEC_HI   = 3'h7
    } seq_state_type;

endpackage

`default_nettype wire

//--- phase_if.sv
// phase timing and synchronised pin levels passed from the clock generator
`timescale 1ns/100ps
`default_nettype none

interface phase_if;
    logic phi1;
    logic phi2;
    logic cycle_end;
    logic rdy_window;
    logic rdy_sample;
    logic ready_s;
    logic irq_b_s;
    logic gate_s;

    modport source (
        output phi1,
        output phi2,
        output cycle_end,
        output rdy_window,
        output rdy_sample,
        output ready_s,
        output irq_b_s,
        output gate_s
    );

    modport sink (
        input phi1,
        input phi2,
        input cycle_end,
        input rdy_window,
        input rdy_sample,
        input ready_s,
        input irq_b_s,
        input gate_s
    );
endinterface

`default_nettype wire

//--- phase_clock_sync.sv
// two-phase clock generator and three-stage pin synchronisers
`timescale 1ns/100ps
`default_nettype none

module phase_clock_sync
    import cpu_bus_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ready,
    input  wire logic irq_b,
    input  wire logic data_output_gate,
    phase_if.source   ph
);

    typedef struct packed {
        logic [CNT_W-1:0]  cnt;
        logic              phi1;
        logic              phi2;
        logic [SYNC_N-1:0] s1;
        logic [SYNC_N-1:0] s2;
        logic [SYNC_N-1:0] s3;
        logic [SYNC_N-1:0] stable;
    } gen_state_type;

    localparam gen_state_type GEN_RESET = '{
        cnt:    '0,
        phi1:   1'h0,
        phi2:   1'h0,
        s1:     SYNC_RESET,
        s2:     SYNC_RESET,
        s3:     SYNC_RESET,
        stable: SYNC_RESET
    };

    gen_state_type q;
    gen_state_type n;

    // ****************************************
    // divider and synchronisers
    // ****************************************
    always_comb begin
        n = q;
        // phases come from the divider with a dead clock between them
        n.cnt  = (q.cnt == CNT_LAST) ? '0 : q.cnt + CNT_STEP;
        n.phi1 = (n.cnt <= PHI1_LAST);
        n.phi2 = (n.cnt >= PHI2_START) && (n.cnt <= PHI2_LAST);
        n.s1   = {data_output_gate, irq_b, ready};
        n.s2   = q.s1;
        n.s3   = q.s2;
        // a level counts only once two later stages agree
        for (int i = 0; i < SYNC_N; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                n.stable[i] = q.s2[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= GEN_RESET;
        end else begin
            q <= n;
        end
    end

    assign ph.phi1       = q.phi1;
    assign ph.phi2       = q.phi2;
    assign ph.cycle_end  = (q.cnt == CNT_LAST);
    assign ph.rdy_window = (q.cnt <= RDY_SAMPLE);
    assign ph.rdy_sample = (q.cnt == RDY_SAMPLE);
    assign ph.ready_s    = q.stable[IN_READY];
    assign ph.irq_b_s    = q.stable[IN_IRQ];
    assign ph.gate_s     = q.stable[IN_GATE];

endmodule

`default_nettype wire

//--- cpu_bus_ready_irq_control.sv
// bus cycle sequencer with ready stall, data gating and maskable interrupt entry
`timescale 1ns/100ps
`default_nettype none

module cpu_bus_ready_irq_control
    import cpu_bus_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              ready,
    input  wire logic              irq_b,
    input  wire logic              data_output_gate,
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_out,
    output logic                   data_oe,
    output logic      [ADDR_W-1:0] addr,
    output logic                   read_write,
    output logic                   phi1_out,
    output logic                   phi2_out,
    output logic                   bus_halted,
    input  wire logic [ADDR_W-1:0] core_addr,
    input  wire logic              core_write,
    input  wire logic [DATA_W-1:0] core_wdata,
    input  wire logic              core_last,
    input  wire logic [ADDR_W-1:0] core_pc,
    input  wire logic [DATA_W-1:0] core_status,
    input  wire logic [DATA_W-1:0] core_sp,
    input  wire logic              core_mask_set,
    input  wire logic              core_mask_clear,
    output logic                   core_ack,
    output logic      [DATA_W-1:0] core_rdata,
    output logic                   vector_valid,
    output logic      [ADDR_W-1:0] vector_addr,
    output logic                   vector_from_reset,
    output logic      [DATA_W-1:0] stack_ptr_out,
    output logic                   irq_mask
);

    typedef struct packed {
        seq_state_type     state;
        logic [ADDR_W-1:0] addr;
        logic              read;
        logic [DATA_W-1:0] wdata;
        logic              last;
        logic              rdy_low;
        logic              halt;
        logic              irq_pend;
        logic              mask;
        logic [ADDR_W-1:0] pc;
        logic [DATA_W-1:0] status;
        logic [DATA_W-1:0] sp;
        logic [DATA_W-1:0] vec_lo;
        logic [DATA_W-1:0] rdata;
        logic              ack;
        logic              vec_valid;
        logic [ADDR_W-1:0] vec;
        logic              from_reset;
        logic [DATA_W-1:0] sp_out;
    } seq_q_type;

    localparam seq_q_type SEQ_RESET = '{
        state:      ST_RST_LO,
        addr:       VEC_RST_LO,
        read:       1'h1,
        wdata:      '0,
        last:       1'h0,
        rdy_low:    1'h0,
        halt:       1'h0,
        irq_pend:   1'h0,
        mask:       MASK_RESET,
        pc:         '0,
        status:     '0,
        sp:         '0,
        vec_lo:     '0,
        rdata:      '0,
        ack:        1'h0,
        vec_valid:  1'h0,
        vec:        '0,
        from_reset: 1'h0,
        sp_out:     '0
    };

    phase_if ph ();

    phase_clock_sync u_phase (
        .clk              (clk),
        .rst_b            (rst_b),
        .ready            (ready),
        .irq_b            (irq_b),
        .data_output_gate (data_output_gate),
        .ph               (ph.source)
    );

    seq_q_type q;
    seq_q_type n;

    // ****************************************
    // bus cycle sequencer
    // ****************************************
    always_comb begin
        logic              stall;
        logic [ADDR_W-1:0] vec_word;
        logic [DATA_W-1:0] sp_next;
        stall    = q.read && q.rdy_low;
        vec_word = {data_in, q.vec_lo};
        sp_next  = q.sp - SP_DEC;
        n = q;
        n.ack       = 1'h0;
        n.vec_valid = 1'h0;
        // ready window runs from phase one start into early phase two
        if (ph.cycle_end) begin
            n.rdy_low = 1'h0;
        end else if (ph.rdy_window && !ph.ready_s) begin
            n.rdy_low = 1'h1;
        end
        // level request, resampled each phase two only while ready high
        if (ph.rdy_sample && ph.ready_s) begin
            n.irq_pend = !ph.irq_b_s;
        end
        if (core_mask_clear) begin
            n.mask = 1'h0;
        end
        if (core_mask_set) begin
            n.mask = 1'h1;
        end
        if (ph.cycle_end) begin
            // writes never stall; a halted read repeats with its address held
            n.halt = stall;
            if (!stall) begin
                n.rdata = data_in;
                case (q.state)
                    ST_RST_LO: begin
                        n.vec_lo = data_in;
                        n.state  = ST_RST_HI;
                        n.addr   = VEC_RST_HI;
                        n.read   = 1'h1;
                    end
                    ST_RST_HI: begin
                        n.mask       = 1'h1;
                        n.state      = ST_RUN;
                        n.vec        = vec_word;
                        n.vec_valid  = 1'h1;
                        n.from_reset = 1'h1;
                        n.addr       = vec_word;
                        n.read       = 1'h1;
                        n.last       = 1'h0;
                    end
                    ST_RUN: begin
                        n.ack = 1'h1;
                        // only at an instruction boundary, mask clear and ready high
                        if (q.last && q.irq_pend && !q.mask && ph.ready_s) begin
                            n.state  = ST_PUSH_PCH;
                            n.pc     = core_pc;
                            n.status = core_status;
                            n.sp     = core_sp;
                            n.addr   = {STACK_PAGE, core_sp};
                            n.read   = 1'h0;
                            n.wdata  = core_pc[ADDR_W-1:DATA_W];
                        end else begin
                            n.addr  = core_addr;
                            n.read  = !core_write;
                            n.wdata = core_wdata;
                            n.last  = core_last;
                        end
                    end
                    ST_PUSH_PCH: begin
                        n.state = ST_PUSH_PCL;
                        n.sp    = sp_next;
                        n.addr  = {STACK_PAGE, sp_next};
                        n.wdata = q.pc[DATA_W-1:0];
                    end
                    ST_PUSH_PCL: begin
                        n.state = ST_PUSH_P;
                        n.sp    = sp_next;
                        n.addr  = {STACK_PAGE, sp_next};
                        n.wdata = q.status;
                    end
                    ST_PUSH_P: begin
                        // set after the clear above, so the entry wins a same-cycle clear
                        n.mask  = 1'h1;
                        n.sp    = sp_next;
                        n.state = ST_VEC_LO;
                        n.addr  = VEC_IRQ_LO;
                        n.read  = 1'h1;
                    end
                    ST_VEC_LO: begin
                        n.vec_lo = data_in;
                        n.state  = ST_VEC_HI;
                        n.addr   = VEC_IRQ_HI;
                    end
                    ST_VEC_HI: begin
                        n.state      = ST_RUN;
                        n.vec        = vec_word;
                        n.vec_valid  = 1'h1;
                        n.from_reset = 1'h0;
                        n.sp_out     = q.sp;
                        n.addr       = vec_word;
                        n.read       = 1'h1;
                        n.last       = 1'h0;
                    end
                    default: begin
                        n.state = ST_RST_LO;
                        n.addr  = VEC_RST_LO;
                        n.read  = 1'h1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= SEQ_RESET;
        end else begin
            q <= n;
        end
    end

    // ****************************************
    // pins and core side
    // ****************************************
    // gate is taken as given; timing it to phase two is left to the system
    assign data_oe           = !q.read && ph.gate_s;
    assign data_out          = q.wdata;
    assign addr              = q.addr;
    assign read_write        = q.read;
    assign phi1_out          = ph.phi1;
    assign phi2_out          = ph.phi2;
    assign bus_halted        = q.halt;
    assign core_ack          = q.ack;
    assign core_rdata        = q.rdata;
    assign vector_valid      = q.vec_valid;
    assign vector_addr       = q.vec;
    assign vector_from_reset = q.from_reset;
    assign stack_ptr_out     = q.sp_out;
    assign irq_mask          = q.mask;

endmodule

`default_nettype wire

//--- bus_ctrl_asserts.sv
// assertion checker for the bus control block, bound to its top
`timescale 1ns/100ps
`default_nettype none

module bus_ctrl_asserts
    import cpu_bus_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic              ready,
    input wire logic              data_output_gate,
    input wire logic              data_oe,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              read_write,
    input wire logic              phi1_out,
    input wire logic              phi2_out,
    input wire logic              bus_halted,
    input wire logic              core_ack,
    input wire logic              vector_valid,
    input wire logic              irq_mask
);
    // ****************
    // helper counters
    // ****************
    // saturating, so long idle stretches never wrap back to zero
    logic [5:0] gate_lo_q;
    logic [5:0] rdy_lo_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gate_lo_q <= 6'h0;
            rdy_lo_q  <= 6'h0;
        end else begin
            gate_lo_q <= data_output_gate ? 6'h0 : ((&gate_lo_q) ? gate_lo_q : gate_lo_q + 6'h1);
            rdy_lo_q  <= ready ? 6'h0 : ((&rdy_lo_q) ? rdy_lo_q : rdy_lo_q + 6'h1);
        end
    end

    // ****************
    // properties
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_oe_write;
        data_oe |-> !read_write;
    endproperty
    a_oe_write: assert property (p_oe_write)
        else $error("data drivers on during a read");

    // synchroniser needs a few clocks, hence the margin of six
    property p_gate_off;
        gate_lo_q >= 6'h06 |-> !data_oe;
    endproperty
    a_gate_off: assert property (p_gate_off)
        else $error("data drivers on with gate low");

    property p_phase_excl;
        !(phi1_out && phi2_out);
    endproperty
    a_phase_excl: assert property (p_phase_excl)
        else $error("phase clocks overlap");

    property p_addr_phi2;
        phi2_out && $past(phi2_out) |-> $stable(addr) && $stable(read_write);
    endproperty
    a_addr_phi2: assert property (p_addr_phi2)
        else $error("address moved inside phase two");

    property p_halt_hold;
        $rose(bus_halted) |-> $stable(addr);
    endproperty
    a_halt_hold: assert property (p_halt_hold)
        else $error("address lost on halt");

    property p_halt_read;
        bus_halted |-> read_write;
    endproperty
    a_halt_read: assert property (p_halt_read)
        else $error("halt on a write cycle");

    property p_stall_ack;
        rdy_lo_q >= 6'h20 && $past(read_write) |-> !(core_ack || vector_valid);
    endproperty
    a_stall_ack: assert property (p_stall_ack)
        else $error("read completed with ready low");

    property p_ack_space;
        core_ack |=> (!core_ack && !vector_valid) [*8];
    endproperty
    a_ack_space: assert property (p_ack_space)
        else $error("completions too close");

    property p_vec_mask;
        vector_valid |-> irq_mask;
    endproperty
    a_vec_mask: assert property (p_vec_mask)
        else $error("mask clear at vector fetch");
endmodule

bind cpu_bus_ready_irq_control bus_ctrl_asserts i_chk (
    .clk, .rst_b, .ready, .data_output_gate, .data_oe, .addr, .read_write,
    .phi1_out, .phi2_out, .bus_halted, .core_ack, .vector_valid, .irq_mask
);

`default_nettype wire

//--- bus_memory_model.sv
// memory and bus-side model: vector table, write log, ready and gate drive
`timescale 1ns/100ps
`default_nettype none

module bus_memory_model
    import cpu_bus_pkg::*;
#(
    parameter logic [ADDR_W-1:0] RST_TGT = 16'h8000,
    parameter logic [ADDR_W-1:0] IRQ_TGT = 16'h1234
)
(
    input  wire logic              clk,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              read_write,
    input  wire logic [DATA_W-1:0] data_out,
    input  wire logic              data_oe,
    input  wire logic              phi2_out,
    input  wire logic              slow,
    input  wire logic              gate_off,
    output logic      [DATA_W-1:0] data_in,
    output logic                   ready,
    output logic                   data_output_gate
);
    logic [23:0] wlog[$];
    logic        p2_q;

    assign data_output_gate = phi2_out && !gate_off;
    assign ready            = !slow;

    // off a read the bus is not ours: show the inverse of data_out, never stale data
    always_comb begin
        case (addr)
            VEC_RST_LO: data_in = RST_TGT[7:0];
            VEC_RST_HI: data_in = RST_TGT[15:8];
            VEC_IRQ_LO: data_in = IRQ_TGT[7:0];
            VEC_IRQ_HI: data_in = IRQ_TGT[15:8];
            default:    data_in = addr[7:0] ^ 8'h5A;
        endcase
        if (!read_write) begin
            data_in = ~data_out;
        end
    end

    // a write lands as phase two ends; the drivers trail the synchronised gate
    // into the next cycle, so their fall would pair the wrong address and data
    always_ff @(posedge clk) begin
        p2_q <= phi2_out;
        if (p2_q && !phi2_out && !read_write && data_oe) begin
            wlog.push_back({addr, data_out});
        end
    end
endmodule

`default_nettype wire

//--- cpu_bus_ready_irq_control_bench.sv
// self-checking bench for the bus control block
`timescale 1ns/100ps
`default_nettype none

module cpu_bus_ready_irq_control_bench;
    import cpu_bus_pkg::*;

    localparam logic [ADDR_W-1:0] RST_TGT = 16'h8000;
    localparam logic [ADDR_W-1:0] IRQ_TGT = 16'h1234;
    localparam logic [ADDR_W-1:0] PC_VAL  = 16'hA5C3;
    localparam logic [DATA_W-1:0] ST_VAL  = 8'h24;
    localparam logic [DATA_W-1:0] SP_VAL  = 8'hF0;

    logic              clk, rst_b, ready, irq_b, data_output_gate, slow, gate_off;
    logic              data_oe, read_write, phi1_out, phi2_out, bus_halted, core_ack;
    logic              core_write, core_last, core_mask_set, core_mask_clear;
    logic              vector_valid, vector_from_reset, irq_mask;
    logic [DATA_W-1:0] data_in, data_out, core_wdata, core_status, core_sp;
    logic [DATA_W-1:0] core_rdata, stack_ptr_out;
    logic [ADDR_W-1:0] addr, core_addr, core_pc, vector_addr;
    int                err_total, n_checks, n_ack, n_vec;

    cpu_bus_ready_irq_control i_dut (
        .clk, .rst_b, .ready, .irq_b, .data_output_gate, .data_in, .data_out, .data_oe,
        .addr, .read_write, .phi1_out, .phi2_out, .bus_halted, .core_addr, .core_write,
        .core_wdata, .core_last, .core_pc, .core_status, .core_sp, .core_mask_set,
        .core_mask_clear, .core_ack, .core_rdata, .vector_valid, .vector_addr,
        .vector_from_reset, .stack_ptr_out, .irq_mask
    );

    bus_memory_model #(.RST_TGT(RST_TGT), .IRQ_TGT(IRQ_TGT)) i_mem (
        .clk, .addr, .read_write, .data_out, .data_oe, .phi2_out, .slow, .gate_off,
        .data_in, .ready, .data_output_gate
    );

    // ****************
    // shared tasks
    // ****************
    task automatic run(input int n);
        n_ack = 0;
        n_vec = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            n_ack += core_ack;
            n_vec += vector_valid;
        end
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ****************
    // scenarios
    // ****************
    task automatic test_reset;
        #1;
        chk(addr, VEC_RST_LO);
        chk({data_oe, irq_mask}, 2'h1);
        rst_b = 1'b1;
        run(60);
        chk(n_vec, 1);
        chk({vector_from_reset, vector_addr}, {1'b1, RST_TGT});
        $display("test_reset done");
    endtask

    // masked, mid-instruction and not-ready phases must all hold the request off
    task automatic test_irq;
        irq_b = 1'b0;
        run(100);
        chk(n_vec, 0);
        chk(n_ack > 0, 1'b1);
        core_last = 1'b0;
        run(30);
        core_mask_clear = 1'b1;
        run(1);
        core_mask_clear = 1'b0;
        run(100);
        chk({irq_mask, n_vec == 0}, 2'h1);
        i_mem.wlog.delete();
        slow = 1'b1;
        core_last = 1'b1;
        run(30);
        run(125);
        chk(n_ack + n_vec, 0);
        chk(i_mem.wlog.size(), 0);
        slow = 1'b0;
        run(250);
        chk(n_vec, 1);
        chk({vector_from_reset, vector_addr}, {1'b0, IRQ_TGT});
        chk({stack_ptr_out, irq_mask}, {SP_VAL - 8'h3, 1'b1});
        chk(i_mem.wlog.size(), 3);
        chk(i_mem.wlog[0], {STACK_PAGE, SP_VAL, PC_VAL[15:8]});
        chk(i_mem.wlog[1], {STACK_PAGE, SP_VAL - 8'h1, PC_VAL[7:0]});
        chk(i_mem.wlog[2], {STACK_PAGE, SP_VAL - 8'h2, ST_VAL});
        irq_b = 1'b1;
        $display("test_irq done");
    endtask

    task automatic test_stall;
        slow = 1'b1;
        run(30);
        run(75);
        chk(addr, core_addr);
        chk({bus_halted, read_write, n_ack == 0}, 3'h7);
        slow = 1'b0;
        run(60);
        chk(n_ack > 0, 1'b1);
        chk(core_rdata, 8'h4A);
        $display("test_stall done");
    endtask

    task automatic test_write;
        time t0;
        {core_write, core_last} = 2'h2;
        i_mem.wlog.delete();
        run(75);
        chk(i_mem.wlog[$], 24'h80105A);
        slow = 1'b1;
        run(100);
        chk({n_ack >= 3, bus_halted}, 2'h2);
        core_write = 1'b0;
        run(100);
        chk({n_ack <= 1, bus_halted}, 2'h3);
        {slow, core_write, gate_off} = 3'h3;
        run(30);
        i_mem.wlog.delete();
        run(100);
        chk(i_mem.wlog.size(), 0);
        chk(n_ack >= 3, 1'b1);
        gate_off = 1'b0;
        // both mask strobes in one clock: the set must win
        core_mask_clear = 1'b1;
        run(1);
        chk(irq_mask, 1'b0);
        core_mask_set = 1'b1;
        run(1);
        chk(irq_mask, 1'b1);
        {core_mask_set, core_mask_clear} = 2'h0;
        @(posedge phi1_out);
        t0 = $time;
        #1;
        chk({phi1_out, phi2_out}, 2'h2);
        @(posedge phi2_out);
        #1;
        chk({phi1_out, phi2_out}, 2'h1);
        @(posedge phi1_out);
        chk(24'($time - t0), 24'(CYCLE_NS));
        $display("test_write done");
    endtask

    // ****************
    // sequence
    // ****************
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        {rst_b, slow, gate_off, core_write, core_mask_set, core_mask_clear} = 6'h0;
        {irq_b, core_last} = 2'h3;
        {core_addr, core_wdata} = 24'h80105A;
        {core_pc, core_status, core_sp} = {PC_VAL, ST_VAL, SP_VAL};
        repeat (2) @(posedge clk);
        test_reset;
        test_irq;
        test_stall;
        test_write;
        report_and_stop;
    end

    // tests need about 1300 clocks; four times that means a hang
    initial begin
        #200000;
        err_total++;
        report_and_stop;
    end
endmodule

`default_nettype wire
